/* rtl/och_pkg.sv */
// Purpose: shared constants and types for the overhead command handshake
// Assumes: one overhead message per frame strobe, 25 MHz system clock
// Notes: both ends import this package
package och_pkg;
	localparam int OCH_OCTETS = 3;
	localparam logic [7:0] OCH_OP_IDLE = 8'hFF;
	localparam logic [7:0] OCH_OP_EOPS = 8'hFC;
	localparam logic [7:0] OCH_OP_REFUSE = 8'hF0;
	localparam logic [15:0] OCH_DATA_IDLE = 16'h0000;
	localparam logic [23:0] OCH_IDLE_MSG = {OCH_OP_IDLE, OCH_DATA_IDLE};
	localparam int OCH_SAMPLES = 3;
	localparam int OCH_MIN_IDLES = 4;
	localparam int OCH_CLK_HZ = 25_000_000;
	localparam int OCH_LIMIT_MS = 900;
	localparam int OCH_LIMIT_CYC = OCH_CLK_HZ / 1000 * OCH_LIMIT_MS;
	localparam int OCH_CNT_W = 32;

	typedef logic [OCH_OCTETS*8-1:0] och_msg_t;

	// Message builder used by both ends
	function automatic och_msg_t och_make(input logic [7:0] op,
		input logic [15:0] dat);
		och_make = {op, dat};
	endfunction : och_make

	// True when a received word is a control command
	function automatic logic och_is_cmd(input och_msg_t m);
		och_is_cmd = (m[23:16] != OCH_OP_IDLE) &&
			(m[23:16] != OCH_OP_EOPS) && (m[23:16] != OCH_OP_REFUSE);
	endfunction : och_is_cmd
endpackage : och_pkg

/* rtl/och_link_if.sv */
// Purpose: frame-rate overhead field exchange between the two ends
// Assumes: frameStb marks one frame slot, shared by both ends
// Notes: each direction carries one three-octet message per frame
interface och_link_if;
	import och_pkg::*;
	logic frameStb;
	och_msg_t downMsg;
	och_msg_t upMsg;
	modport operator_side_unit (input frameStb, output downMsg,
		input upMsg);
	modport remote_side_unit (input frameStb, input downMsg,
		output upMsg);
endinterface : och_link_if

/* rtl/och_remote.sv */
// Purpose: remote-side handshake engine
// Assumes: user answers each latched command within the same cycle
// Notes: sampleEn lets the user sample fewer frames than arrive
module och_remote import och_pkg::*; #(
	parameter int LIMIT_CYC = OCH_LIMIT_CYC
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic clkEn,
	och_link_if.remote_side_unit link,
	input wire logic sampleEn,
	input wire logic eopsActive,
	input wire logic [15:0] eopsTxData,
	output logic [15:0] eopsRxData,
	output logic eopsRxValid,
	output logic cmdValid,
	output och_msg_t cmdMsg,
	input wire logic cmdOptional,
	input wire logic cmdRefuse,
	input wire logic [15:0] readData,
	input wire logic cmdIsRead,
	output logic busy,
	output logic timeoutFlag
);
	// Elaboration check: the limit timer needs room to count
	if (LIMIT_CYC < 2) begin : limitCheck
		$error("LIMIT_CYC too small");
	end

	typedef enum logic [2:0] {
		RS_IDLE = 3'b001,
		RS_ECHO = 3'b010,
		RS_TAIL = 3'b100
	} och_rst_t;

	och_rst_t state_q, state_d;
	och_msg_t last_q, last_d, tx_q, tx_d, cmd_q, cmd_d;
	logic [1:0] msgCnt_q, msgCnt_d;
	logic [2:0] idleCnt_q, idleCnt_d;
	logic [OCH_CNT_W-1:0] timer_q, timer_d;
	logic valid_q, valid_d, tmo_q, tmo_d;
	logic [15:0] eRx_q, eRx_d;
	logic eVal_q, eVal_d;
	logic smp;

	assign smp = link.frameStb && sampleEn;
	assign link.upMsg = tx_q;
	assign cmdValid = valid_q;
	assign cmdMsg = cmd_q;
	assign busy = (state_q != RS_IDLE);
	assign timeoutFlag = tmo_q;
	assign eopsRxData = eRx_q;
	assign eopsRxValid = eVal_q;

	// Next state of the handshake
	always_comb begin
		state_d = state_q;
		last_d = last_q;
		tx_d = tx_q;
		cmd_d = cmd_q;
		msgCnt_d = msgCnt_q;
		idleCnt_d = idleCnt_q;
		timer_d = timer_q;
		valid_d = 1'b0;
		tmo_d = tmo_q;
		eRx_d = eRx_q;
		eVal_d = 1'b0;
		if (state_q != RS_IDLE)
			timer_d = timer_q + 1'b1;
		case (state_q)
			RS_IDLE: begin
				if (link.frameStb)
					tx_d = eopsActive ? och_make(OCH_OP_EOPS, eopsTxData)
						: OCH_IDLE_MSG;
				if (smp && link.downMsg[23:16] == OCH_OP_EOPS) begin
					eRx_d = link.downMsg[15:0];
					eVal_d = 1'b1;
				end
				if (smp) begin
					last_d = link.downMsg;
					if (!och_is_cmd(link.downMsg))
						msgCnt_d = 2'd0;
					else if (msgCnt_q == 2'd0 || link.downMsg != last_q)
						msgCnt_d = 2'd1;
					else
						msgCnt_d = msgCnt_q + 2'd1;
					if (och_is_cmd(link.downMsg) && msgCnt_q ==
						2'(OCH_SAMPLES - 1) && link.downMsg == last_q) begin
						cmd_d = link.downMsg;
						valid_d = 1'b1;
						timer_d = '0;
						tmo_d = 1'b0;
						msgCnt_d = 2'd0;
						state_d = RS_ECHO;
						if (cmdRefuse && cmdOptional)
							tx_d = och_make(OCH_OP_REFUSE,
								link.downMsg[15:0]);
						else if (cmdIsRead)
							tx_d = och_make(link.downMsg[23:16], readData);
						else
							tx_d = link.downMsg;
					end
				end
			end
			RS_ECHO: begin
				if (smp && link.downMsg == OCH_IDLE_MSG) begin
					tx_d = OCH_IDLE_MSG;
					idleCnt_d = 3'd0;
					state_d = RS_TAIL;
				end
			end
			RS_TAIL: begin
				tx_d = OCH_IDLE_MSG;
				if (link.frameStb) begin
					idleCnt_d = idleCnt_q + 3'd1;
					if (idleCnt_q == 3'(OCH_MIN_IDLES - 1))
						state_d = RS_IDLE;
				end
			end
			default: state_d = RS_IDLE;
		endcase
		if (state_q != RS_IDLE && timer_q >= OCH_CNT_W'(LIMIT_CYC)) begin
			state_d = RS_IDLE;
			tx_d = OCH_IDLE_MSG;
			msgCnt_d = 2'd0;
			timer_d = '0;
			tmo_d = 1'b1;
		end
	end

	// Registers, frozen while clkEn is low
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state_q <= RS_IDLE;
			last_q <= OCH_IDLE_MSG;
			tx_q <= OCH_IDLE_MSG;
			cmd_q <= OCH_IDLE_MSG;
			msgCnt_q <= 2'd0;
			idleCnt_q <= 3'd0;
			timer_q <= '0;
			valid_q <= 1'b0;
			tmo_q <= 1'b0;
			eRx_q <= 16'h0000;
			eVal_q <= 1'b0;
		end else if (clkEn) begin
			state_q <= state_d;
			last_q <= last_d;
			tx_q <= tx_d;
			cmd_q <= cmd_d;
			msgCnt_q <= msgCnt_d;
			idleCnt_q <= idleCnt_d;
			timer_q <= timer_d;
			valid_q <= valid_d;
			tmo_q <= tmo_d;
			eRx_q <= eRx_d;
			eVal_q <= eVal_d;
		end
	end
endmodule : och_remote

/* rtl/och_operator.sv */
// Purpose: operator-side handshake engine
// Assumes: one command request at a time, long words sent as a series
// Notes: continuation words are simply further requests (header first)
module och_operator import och_pkg::*; #(
	parameter int LIMIT_CYC = OCH_LIMIT_CYC
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic clkEn,
	och_link_if.operator_side_unit link,
	input wire logic sampleEn,
	input wire logic eopsActive,
	input wire logic [15:0] eopsTxData,
	input wire logic reqValid,
	output logic reqReady,
	input wire och_msg_t reqMsg,
	output logic doneValid,
	output och_msg_t doneReply,
	output logic doneRefused,
	output logic timeoutFlag
);
	// Elaboration check: the limit timer needs room to count
	if (LIMIT_CYC < 2) begin : limitCheck
		$error("LIMIT_CYC too small");
	end

	typedef enum logic [2:0] {
		OS_IDLE = 3'b001,
		OS_CMD = 3'b010,
		OS_WAIT = 3'b100
	} och_ost_t;

	och_ost_t state_q, state_d;
	och_msg_t cmd_q, cmd_d, tx_q, tx_d, last_q, last_d, rep_q, rep_d;
	logic [2:0] idleCnt_q, idleCnt_d;
	logic [1:0] echoCnt_q, echoCnt_d;
	logic [OCH_CNT_W-1:0] timer_q, timer_d;
	logic done_q, done_d, ref_q, ref_d, tmo_q, tmo_d;
	logic smp, good;

	assign smp = link.frameStb && sampleEn;
	assign link.downMsg = tx_q;
	assign reqReady = (state_q == OS_IDLE) &&
		(idleCnt_q >= 3'(OCH_MIN_IDLES)) && !eopsActive;
	assign doneValid = done_q;
	assign doneReply = rep_q;
	assign doneRefused = ref_q;
	assign timeoutFlag = tmo_q;
	// Correct answer is any word with the command's opcode or refusal of same data
	assign good = (link.upMsg[23:16] == cmd_q[23:16]) ||
		(link.upMsg == och_make(OCH_OP_REFUSE, cmd_q[15:0]));

	// Next state of the handshake
	always_comb begin
		state_d = state_q;
		cmd_d = cmd_q;
		tx_d = tx_q;
		last_d = last_q;
		rep_d = rep_q;
		idleCnt_d = idleCnt_q;
		echoCnt_d = echoCnt_q;
		timer_d = timer_q;
		done_d = 1'b0;
		ref_d = ref_q;
		tmo_d = tmo_q;
		if (state_q != OS_IDLE)
			timer_d = timer_q + 1'b1;
		case (state_q)
			OS_IDLE: begin
				if (link.frameStb) begin
					tx_d = eopsActive ? och_make(OCH_OP_EOPS, eopsTxData)
						: OCH_IDLE_MSG;
					// count idles already on the link only
					if (!eopsActive && tx_q == OCH_IDLE_MSG &&
						idleCnt_q < 3'(OCH_MIN_IDLES))
						idleCnt_d = idleCnt_q + 3'd1;
					else if (eopsActive)
						idleCnt_d = 3'd0;
				end
				if (reqValid && reqReady) begin
					cmd_d = reqMsg;
					timer_d = '0;
					tmo_d = 1'b0;
					echoCnt_d = 2'd0;
					state_d = OS_CMD;
				end
			end
			OS_CMD: begin
				tx_d = cmd_q;
				if (smp) begin
					last_d = link.upMsg;
					if (!good)
						echoCnt_d = 2'd0;
					else if (echoCnt_q == 2'd0 || link.upMsg != last_q)
						echoCnt_d = 2'd1;
					else
						echoCnt_d = echoCnt_q + 2'd1;
					if (good && echoCnt_q == 2'(OCH_SAMPLES - 1) &&
						link.upMsg == last_q) begin
						rep_d = link.upMsg;
						ref_d = (link.upMsg[23:16] == OCH_OP_REFUSE);
						tx_d = OCH_IDLE_MSG;
						state_d = OS_WAIT;
					end
				end
			end
			OS_WAIT: begin
				tx_d = OCH_IDLE_MSG;
				if (smp && link.upMsg == OCH_IDLE_MSG) begin
					done_d = 1'b1;
					idleCnt_d = 3'd0;
					state_d = OS_IDLE;
				end
			end
			default: state_d = OS_IDLE;
		endcase
		if (state_q != OS_IDLE && timer_q >= OCH_CNT_W'(LIMIT_CYC)) begin
			state_d = OS_IDLE;
			tx_d = OCH_IDLE_MSG;
			echoCnt_d = 2'd0;
			idleCnt_d = 3'd0;
			timer_d = '0;
			tmo_d = 1'b1;
		end
	end

	// Registers, frozen while clkEn is low
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state_q <= OS_IDLE;
			cmd_q <= OCH_IDLE_MSG;
			tx_q <= OCH_IDLE_MSG;
			last_q <= OCH_IDLE_MSG;
			rep_q <= OCH_IDLE_MSG;
			idleCnt_q <= 3'd0;
			echoCnt_q <= 2'd0;
			timer_q <= '0;
			done_q <= 1'b0;
			ref_q <= 1'b0;
			tmo_q <= 1'b0;
		end else if (clkEn) begin
			state_q <= state_d;
			cmd_q <= cmd_d;
			tx_q <= tx_d;
			last_q <= last_d;
			rep_q <= rep_d;
			idleCnt_q <= idleCnt_d;
			echoCnt_q <= echoCnt_d;
			timer_q <= timer_d;
			done_q <= done_d;
			ref_q <= ref_d;
			tmo_q <= tmo_d;
		end
	end
endmodule : och_operator

/* bench/och_link_chk.sv */
// Purpose: link checks for the overhead command handshake
// Assumes: one clock, link signals seen as plain inputs
// Notes: strobe counters saturate at seven
module och_link_chk import och_pkg::*; (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic frameStb,
	input wire och_msg_t downMsg,
	input wire och_msg_t upMsg
);
	timeunit 1ns;
	timeprecision 1ns;
	// ****************
	// Steady strobes
	// ****************
	och_msg_t dnOld_q, upOld_q;
	logic [2:0] dnCnt_q, dnCnt_d, upCnt_q, upCnt_d;
	logic dnCmd, upAns;
	// Status codes never count as commands
	assign dnCmd = !(downMsg[23:16] inside {OCH_OP_IDLE, OCH_OP_EOPS,
		OCH_OP_REFUSE});
	assign upAns = !(upMsg[23:16] inside {OCH_OP_IDLE, OCH_OP_EOPS});
	// A change restarts a count, so only steady words build one
	always_comb begin
		dnCnt_d = (downMsg != dnOld_q) ? 3'h0 : dnCnt_q;
		upCnt_d = (upMsg != upOld_q) ? 3'h0 : upCnt_q;
		dnCnt_d = dnCnt_d + {2'h0, frameStb && dnCnt_d != 3'h7};
		upCnt_d = upCnt_d + {2'h0, frameStb && upCnt_d != 3'h7};
	end
	// Register the counts
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			dnCnt_q <= 3'h0;
			upCnt_q <= 3'h0;
			dnOld_q <= OCH_IDLE_MSG;
			upOld_q <= OCH_IDLE_MSG;
		end else begin
			dnCnt_q <= dnCnt_d;
			upCnt_q <= upCnt_d;
			dnOld_q <= downMsg;
			upOld_q <= upMsg;
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	reply_cause_a: assert property (
		$changed(upMsg) && upAns |-> $past(dnCmd))
		else $error("reply without a command");
	echo_opcode_a: assert property (
		$changed(upMsg) && upAns && upMsg[23:16] != OCH_OP_REFUSE
		|-> upMsg[23:16] == downMsg[23:16]) else $error("echo opcode");
	refuse_data_a: assert property (
		$changed(upMsg) && upMsg[23:16] == OCH_OP_REFUSE
		|-> upMsg[15:0] == downMsg[15:0]) else $error("refusal data");
	latch_count_a: assert property (
		$changed(upMsg) && upAns |-> dnCnt_q >= 3'h3)
		else $error("latched too early");
	cmd_hold_a: assert property (
		$past(dnCmd) && $changed(downMsg) |-> downMsg == OCH_IDLE_MSG)
		else $error("command dropped");
	echo_done_a: assert property (
		$changed(downMsg) && $past(dnCmd) && upAns |-> upCnt_q >= 3'h3)
		else $error("idle before three echoes");
	echo_hold_a: assert property (
		$past(upAns) && $changed(upMsg)
		|-> upMsg == OCH_IDLE_MSG && $past(downMsg) == OCH_IDLE_MSG)
		else $error("echo left early");
	idle_tail_a: assert property (
		$changed(upMsg) && $past(upMsg) == OCH_IDLE_MSG |-> upCnt_q >= 3'h4)
		else $error("short remote idle run");
	idle_lead_a: assert property (
		$changed(downMsg) && dnCmd |-> dnCnt_q >= 3'h4)
		else $error("short operator idle run");
endmodule : och_link_chk

/* bench/tb.sv */
// Purpose: bench joining both handshake ends across one link
// Assumes: strobe every fifth clock, remote samples every other one
// Notes: short time limit keeps the timeout case quick
module tb import och_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ns;
	// ****************
	// Bench
	// ****************
	logic sys_clk, rst, opEops, reqValid, cmdOptional, cmdRefuse;
	logic cmdIsRead, sampOff, rmSample, reqReady, doneValid;
	logic doneRefused, opTimeout, eopsRxValid, cmdValid, busy, rmTimeout;
	logic [15:0] opEopsData, readData, eopsRxData;
	logic [2:0] strobeCnt;
	logic run, opSample, rmEops;
	logic [15:0] rmEopsData;
	int latches;
	och_msg_t reqMsg, doneReply, cmdMsg;
	int fail_count, compares;
	och_msg_t cmds [3] = '{24'h02ABCD, 24'h010000, 24'h04C0FF};
	och_msg_t exps [3] = '{24'h02ABCD, 24'h015A3C, 24'hF0C0FF};
	och_link_if och_link_if_i ();
	och_operator #(.LIMIT_CYC(2000)) och_operator_i (.sys_clk, .rst,
		.clkEn(run), .link(och_link_if_i), .sampleEn(opSample),
		.eopsActive(opEops), .eopsTxData(opEopsData), .reqValid, .reqReady,
		.reqMsg, .doneValid, .doneReply, .doneRefused,
		.timeoutFlag(opTimeout));
	och_remote #(.LIMIT_CYC(2000)) och_remote_i (.sys_clk, .rst,
		.clkEn(run), .link(och_link_if_i), .sampleEn(rmSample),
		.eopsActive(rmEops), .eopsTxData(rmEopsData), .eopsRxData,
		.eopsRxValid,
		.cmdValid, .cmdMsg, .cmdOptional, .cmdRefuse, .readData, .cmdIsRead,
		.busy, .timeoutFlag(rmTimeout));
	och_link_chk och_link_chk_i (.sys_clk, .rst,
		.frameStb(och_link_if_i.frameStb), .downMsg(och_link_if_i.downMsg),
		.upMsg(och_link_if_i.upMsg));
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	// Remote skips half the strobes to exercise under-sampling
	always @(posedge sys_clk) begin
		strobeCnt <= (strobeCnt == 3'h4) ? 3'h0 : strobeCnt + 3'h1;
		och_link_if_i.frameStb <= (strobeCnt == 3'h4);
		rmSample <= ~rmSample & ~sampOff;
	end
	// Count latch pulses, one per accepted command
	always @(negedge sys_clk) begin
		if (rst)
			latches <= 0;
		else if (cmdValid === 1'b1)
			latches <= latches + 1;
	end
	task automatic check(input logic [23:0] got, input logic [23:0] exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic results();
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (compares > 0 && fail_count == 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : results
	task automatic hang(input int n);
		if (n >= 3000) begin
			fail_count++;
			$display("Error %0t: wait ran out", $time);
			results();
		end
	endtask : hang
	// Hold the request until taken, then wait for answer or timeout
	task automatic send(input och_msg_t m);
		int n = 0;
		reqValid <= 1'b1;
		reqMsg <= m;
		do begin
			@(negedge sys_clk);
			n++;
		end while (reqReady !== 1'b1 && n < 3000);
		hang(n);
		@(posedge sys_clk);
		reqValid <= 1'b0;
		n = 0;
		do begin
			@(negedge sys_clk);
			n++;
		end while (doneValid !== 1'b1 && opTimeout !== 1'b1 && n < 3000);
		hang(n);
	endtask : send
	initial begin
		{rst, reqValid, opEops, sampOff, rmSample} = 5'h10;
		{cmdOptional, cmdRefuse, cmdIsRead, strobeCnt} = 6'h00;
		{reqMsg, opEopsData, readData} = {24'h000000, 16'h1234, 16'h5A3C};
		och_link_if_i.frameStb = 1'b0;
		{run, opSample, rmEops, rmEopsData} = {3'h6, 16'h5678};
		repeat (5) @(posedge sys_clk);
		rst <= 1'b0;
		@(negedge sys_clk);
		check(och_link_if_i.downMsg, 24'hFF0000);
		check(och_link_if_i.upMsg, 24'hFF0000);
		// Mandatory write, read, then refused optional write
		for (int i = 0; i < 3; i++) begin
			@(posedge sys_clk);
			cmdOptional <= (i == 2);
			cmdRefuse <= (i != 1);
			cmdIsRead <= (i == 1);
			send(cmds[i]);
			check(doneReply, exps[i]);
			check(doneRefused, i == 2);
			check(cmdMsg, cmds[i]);
			check(busy, 1'b1);
		end
		check(24'(latches), 24'h000003);
		// Frozen ends hold the link even when a fill is asked for
		@(posedge sys_clk);
		run <= 1'b0;
		opEops <= 1'b1;
		repeat (12) @(negedge sys_clk);
		check(och_link_if_i.downMsg, 24'hFF0000);
		@(posedge sys_clk);
		run <= 1'b1;
		rmEops <= 1'b1;
		for (int n = 0; eopsRxValid !== 1'b1; n++) begin
			@(negedge sys_clk);
			hang(n);
		end
		check(och_link_if_i.downMsg, 24'hFC1234);
		check(eopsRxData, 16'h1234);
		check(och_link_if_i.upMsg, 24'hFC5678);
		@(posedge sys_clk);
		opEops <= 1'b0;
		rmEops <= 1'b0;
		sampOff <= 1'b1;
		send(24'h030000);
		repeat (10) @(negedge sys_clk);
		check(opTimeout, 1'b1);
		check(och_link_if_i.downMsg, 24'hFF0000);
		check(och_link_if_i.upMsg, 24'hFF0000);
		check(24'(latches), 24'h000003);
		check(busy, 1'b0);
		check(rmTimeout, 1'b0);
		results();
	end
endmodule : tb
